// *** verilog/pocr_pkg.sv ***
// Constants for the output configuration register bank.
// Assumes a 10 MHz device clock and byte-wide command codes.
package pocr_pkg;

	// ==========================================================
	// Command codes
	localparam logic [7:0] CMD_PG_DELAY   = 8'hd4;
	localparam logic [7:0] CMD_RAMP_GAIN  = 8'hd5;
	localparam logic [7:0] CMD_INDUCTANCE = 8'hd6;
	localparam logic [7:0] CMD_CAPT_MASK  = 8'hd7;
	localparam logic [7:0] CMD_FILTER_CFG = 8'hd8;
	localparam logic [7:0] CMD_TEMP_GAIN  = 8'hd9;

	// ==========================================================
	// Values after reset
	localparam logic [15:0] RST_PG_DELAY   = 16'hba00;
	localparam logic [7:0]  RST_RAMP_GAIN  = 8'h03;
	localparam logic [15:0] RST_INDUCTANCE = 16'hb133;
	localparam logic [15:0] RST_CAPT_MASK  = 16'h0000;
	localparam logic [7:0]  RST_FILTER_CFG = 8'h00;
	localparam logic [15:0] RST_TEMP_GAIN  = 16'hba00;

	// ==========================================================
	// Field layouts
	localparam int          L11_EXP_MSB    = 15;
	localparam int          L11_EXP_LSB    = 11;
	localparam int          L11_MANT_MSB   = 10;
	localparam int          FILT_LS_ON_BIT = 7;
	localparam int          FILT_CNT_MSB   = 3;
	localparam logic [15:0] CAPT_USED_BITS = 16'h3cff;
	localparam logic [2:0]  RAIL_4PHASE    = 3'h3;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned PG_TICK_NS    = 125;
	localparam int unsigned PG_MAX_MS     = 500;
	localparam int unsigned NS_PER_MS     = 1000000;
	localparam int unsigned TICK_UNIT_NS  = 25;
	localparam logic [2:0]  CLK_STEP      = 3'(CLK_PERIOD_NS / TICK_UNIT_NS);
	localparam logic [2:0]  TICK_STEP     = 3'(PG_TICK_NS / TICK_UNIT_NS);
	localparam int unsigned TICKS_PER_MS  = NS_PER_MS / PG_TICK_NS;
	localparam int unsigned PG_MAX_TICKS  = PG_MAX_MS * TICKS_PER_MS;

	// ==========================================================
	// Power-good delay states
	typedef enum logic [1:0] {
		PG_IDLE = 2'b00,
		PG_WAIT = 2'b01,
		PG_GOOD = 2'b10
	} pocr_pg_e;

endpackage : pocr_pkg

// *** verilog/pocr_out_chan.sv ***
// One output's power-good delay timer and OV/UV violation filter.
// Assumes monitor inputs synchronous to i_clock.
`timescale 1ns/1ns
`default_nettype none

module pocr_out_chan #(
	parameter int unsigned PG_MAX_TICKS = pocr_pkg::PG_MAX_TICKS
) (
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	// Settings
	input  wire logic [15:0] i_pg_delay,
	input  wire logic [7:0]  i_filter_cfg,
	// Monitor
	input  wire logic        i_vout_above_pg,
	input  wire logic        i_vsample_valid,
	input  wire logic        i_ov_violation,
	input  wire logic        i_uv_violation,
	// Results
	output logic             o_output_good,
	output logic             o_ov_fault,
	output logic             o_uv_fault
);
	import pocr_pkg::*;

	// ==========================================================
	// Delay in 125 ns ticks from the linear-11 value
	logic signed [4:0]  dly_exp;
	logic signed [10:0] dly_mant;
	logic [63:0]        dly_base;
	logic [63:0]        dly_full;
	logic [22:0]        dly_ticks;

	always_comb begin
		dly_exp  = i_pg_delay[L11_EXP_MSB:L11_EXP_LSB];
		dly_mant = i_pg_delay[L11_MANT_MSB:0];
		dly_base = 64'(dly_mant) * 64'(TICKS_PER_MS);
		if (dly_mant <= 0) begin
			dly_full = 64'h0;
		end else if (dly_exp >= 0) begin
			dly_full = dly_base << dly_exp;
		end else begin
			dly_full = dly_base >> (-dly_exp);
		end
		// Beyond the top of the range the delay saturates
		if (dly_full > 64'(PG_MAX_TICKS)) begin
			dly_ticks = 23'(PG_MAX_TICKS);
		end else begin
			dly_ticks = dly_full[22:0];
		end
	end

	// ==========================================================
	// Tick generator: 100 ns clock against a 125 ns step
	pocr_pg_e    state_reg;
	logic [2:0]  frac_reg;
	logic [3:0]  frac_sum;
	logic        tick;
	logic [22:0] cnt_reg;

	assign frac_sum = {1'b0, frac_reg} + {1'b0, CLK_STEP};
	assign tick     = frac_sum >= {1'b0, TICK_STEP};

	always_ff @(posedge i_clock) begin
		if (!i_rst_b || state_reg != PG_WAIT) begin
			frac_reg <= 3'h0;
		end else if (tick) begin
			frac_reg <= 3'(frac_sum - {1'b0, TICK_STEP});
		end else begin
			frac_reg <= frac_sum[2:0];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b || state_reg != PG_WAIT) begin
			cnt_reg <= 23'h0;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 23'h1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			state_reg <= PG_IDLE;
		end else begin
			case (state_reg)
				PG_IDLE: if (i_vout_above_pg) state_reg <= PG_WAIT;
				PG_WAIT: begin
					if (!i_vout_above_pg) begin
						state_reg <= PG_IDLE;
					end else if (cnt_reg >= dly_ticks) begin
						state_reg <= PG_GOOD;
					end
				end
				PG_GOOD: if (!i_vout_above_pg) state_reg <= PG_IDLE;
				default: state_reg <= PG_IDLE;
			endcase
		end
	end

	assign o_output_good = state_reg == PG_GOOD;

	// ==========================================================
	// Consecutive violation counters, OV at 0 and UV at 1
	logic [4:0] need;
	logic [4:0] vcnt_reg [2];
	logic [1:0] viol;
	logic [1:0] fault_reg;

	assign need = {1'b0, i_filter_cfg[FILT_CNT_MSB:0]} + 5'h1;
	assign viol = {i_uv_violation, i_ov_violation};

	always_ff @(posedge i_clock) begin
		for (int k = 0; k < 2; k++) begin
			if (!i_rst_b) begin
				vcnt_reg[k]  <= 5'h0;
				fault_reg[k] <= 1'b0;
			end else begin
				fault_reg[k] <= 1'b0;
				if (i_vsample_valid && !viol[k]) begin
					vcnt_reg[k] <= 5'h0;
				end else if (i_vsample_valid && vcnt_reg[k] < need) begin
					vcnt_reg[k]  <= vcnt_reg[k] + 5'h1;
					fault_reg[k] <= vcnt_reg[k] + 5'h1 == need;
				end
			end
		end
	end

	assign o_ov_fault = fault_reg[0];
	assign o_uv_fault = fault_reg[1];

endmodule // pocr_out_chan

`default_nettype wire

// *** verilog/pocr_regs.sv ***
// Output configuration register bank with its per-output logic.
// Assumes a command port from the bus front end and pins synchronous
// to i_clock; page selects output 0 or 1 for paged settings.
`timescale 1ns/1ns
`default_nettype none

module pocr_regs #(
	parameter int unsigned PG_MAX_TICKS = pocr_pkg::PG_MAX_TICKS
) (
	// Clock and reset
	input  wire logic             i_clock,
	input  wire logic             i_rst_b,
	// Command port
	input  wire logic             i_cmd_valid,
	input  wire logic             i_cmd_write,
	input  wire logic             i_cmd_page,
	input  wire logic [7:0]       i_cmd_code,
	input  wire logic [15:0]      i_cmd_wdata,
	input  wire logic             i_write_protect,
	output logic                  o_rsp_valid,
	output logic [15:0]           o_rsp_rdata,
	output logic                  o_rsp_err,
	// Rail configuration
	input  wire logic [2:0]       i_phases_in_rail,
	// Per-output monitor
	input  wire logic [1:0]       i_vout_above_pg,
	input  wire logic [1:0]       i_vsample_valid,
	input  wire logic [1:0]       i_ov_violation,
	input  wire logic [1:0]       i_uv_violation,
	input  wire logic [1:0]       i_shutdown_cmd,
	input  wire logic [1:0]       i_fault_clear,
	// Per-output PWM from the control loop
	input  wire logic [1:0]       i_hs_pwm_loop,
	input  wire logic [1:0]       i_ls_pwm_loop,
	// Fault events for capture
	input  wire logic [15:0]      i_fault_events,
	// Status and control outputs
	output logic [1:0]            o_output_good_pin,
	output logic [1:0]            o_ov_fault,
	output logic [1:0]            o_uv_fault,
	output logic                  o_multiphase_mode,
	output logic [1:0]            o_fast_adaptive_loop,
	output logic [1:0]            o_soft_off_allowed,
	output logic                  o_snapshot_trigger,
	// PWM pins
	output logic [1:0]            o_high_side_pwm_out,
	output logic [1:0]            o_high_side_pwm_oe,
	output logic [1:0]            o_low_side_pwm_out,
	// Settings to the converter
	output logic [7:0]            o_startup_ramp_gain,
	output logic [1:0][15:0]      o_inductance_value,
	output logic [1:0][15:0]      o_ext_temp_gain
);
	import pocr_pkg::*;

	// ==========================================================
	// Register storage
	logic [15:0] pg_delay_reg    [2];
	logic [7:0]  ramp_gain_reg;
	logic [15:0] inductance_reg  [2];
	logic [15:0] capt_mask_reg;
	logic [7:0]  filter_cfg_reg  [2];
	logic [15:0] temp_gain_reg   [2];

	logic        wr_ok;
	logic        hit;
	logic        pg;

	assign pg    = i_cmd_page;
	assign hit   = i_cmd_code >= CMD_PG_DELAY && i_cmd_code <= CMD_TEMP_GAIN;
	// Protection blocks every write in this bank
	assign wr_ok = i_cmd_valid && i_cmd_write && hit && !i_write_protect;

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			for (int k = 0; k < 2; k++) begin
				pg_delay_reg[k]   <= RST_PG_DELAY;
				inductance_reg[k] <= RST_INDUCTANCE;
				filter_cfg_reg[k] <= RST_FILTER_CFG;
				temp_gain_reg[k]  <= RST_TEMP_GAIN;
			end
			ramp_gain_reg <= RST_RAMP_GAIN;
			capt_mask_reg <= RST_CAPT_MASK;
		end else if (wr_ok) begin
			if (i_cmd_code == CMD_PG_DELAY) begin
				pg_delay_reg[pg] <= i_cmd_wdata;
			end else if (i_cmd_code == CMD_RAMP_GAIN) begin
				ramp_gain_reg <= i_cmd_wdata[7:0];
			end else if (i_cmd_code == CMD_INDUCTANCE) begin
				inductance_reg[pg] <= i_cmd_wdata;
			end else if (i_cmd_code == CMD_CAPT_MASK) begin
				capt_mask_reg <= i_cmd_wdata;
			end else if (i_cmd_code == CMD_FILTER_CFG) begin
				filter_cfg_reg[pg] <= i_cmd_wdata[7:0];
			end else if (i_cmd_code == CMD_TEMP_GAIN) begin
				temp_gain_reg[pg] <= i_cmd_wdata;
			end
		end
	end

	// ==========================================================
	// Read data and response
	logic [15:0] rd_mux;

	always_comb begin
		rd_mux = 16'h0;
		if (i_cmd_code == CMD_PG_DELAY) begin
			rd_mux = pg_delay_reg[pg];
		end else if (i_cmd_code == CMD_RAMP_GAIN) begin
			rd_mux = {8'h0, ramp_gain_reg};
		end else if (i_cmd_code == CMD_INDUCTANCE) begin
			rd_mux = inductance_reg[pg];
		end else if (i_cmd_code == CMD_CAPT_MASK) begin
			rd_mux = capt_mask_reg;
		end else if (i_cmd_code == CMD_FILTER_CFG) begin
			rd_mux = {8'h0, filter_cfg_reg[pg]};
		end else if (i_cmd_code == CMD_TEMP_GAIN) begin
			rd_mux = temp_gain_reg[pg];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_rsp_valid <= 1'b0;
			o_rsp_err   <= 1'b0;
			o_rsp_rdata <= 16'h0;
		end else begin
			o_rsp_valid <= i_cmd_valid;
			// Unknown code, or a blocked write, answers with an error
			o_rsp_err   <= i_cmd_valid && (!hit || (i_cmd_write && i_write_protect));
			o_rsp_rdata <= (i_cmd_valid && !i_cmd_write) ? rd_mux : 16'h0;
		end
	end

	// ==========================================================
	// Ramp mode selection
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_multiphase_mode <= 1'b0;
		end else begin
			o_multiphase_mode <= i_phases_in_rail == RAIL_4PHASE;
		end
	end

	// Standalone keeps the loop on; multiphase waits for output good
	assign o_fast_adaptive_loop = o_multiphase_mode ? o_output_good_pin : 2'b11;
	assign o_soft_off_allowed   = o_multiphase_mode ? 2'b00 : 2'b11;
	// Gain goes straight to the ramp generator; smaller means slower
	assign o_startup_ramp_gain  = ramp_gain_reg;

	// ==========================================================
	// Per-output channels
	logic [1:0] ov_trip_reg;

	for (genvar c = 0; c < 2; c++) begin : g_chan
		pocr_out_chan #(
			.PG_MAX_TICKS (PG_MAX_TICKS)
		) u_chan (
			.i_clock         (i_clock),
			.i_rst_b         (i_rst_b),
			.i_pg_delay      (pg_delay_reg[c]),
			.i_filter_cfg    (filter_cfg_reg[c]),
			.i_vout_above_pg (i_vout_above_pg[c]),
			.i_vsample_valid (i_vsample_valid[c]),
			.i_ov_violation  (i_ov_violation[c]),
			.i_uv_violation  (i_uv_violation[c]),
			.o_output_good   (o_output_good_pin[c]),
			.o_ov_fault      (o_ov_fault[c]),
			.o_uv_fault      (o_uv_fault[c])
		);

		assign o_inductance_value[c] = inductance_reg[c];
		assign o_ext_temp_gain[c]    = temp_gain_reg[c];

		// A new trip in the clearing cycle wins over the clear
		always_ff @(posedge i_clock) begin
			if (!i_rst_b) begin
				ov_trip_reg[c] <= 1'b0;
			end else if (o_ov_fault[c]) begin
				ov_trip_reg[c] <= 1'b1;
			end else if (i_fault_clear[c]) begin
				ov_trip_reg[c] <= 1'b0;
			end
		end

		// ======================================================
		// PWM pin drive
		always_ff @(posedge i_clock) begin
			if (!i_rst_b) begin
				o_high_side_pwm_out[c] <= 1'b0;
				o_high_side_pwm_oe[c]  <= 1'b0;
				o_low_side_pwm_out[c]  <= 1'b0;
			end else if (ov_trip_reg[c]) begin
				o_high_side_pwm_out[c] <= 1'b0;
				o_high_side_pwm_oe[c]  <= 1'b0;
				o_low_side_pwm_out[c]  <= filter_cfg_reg[c][FILT_LS_ON_BIT];
			end else if (o_multiphase_mode && i_shutdown_cmd[c]) begin
				o_high_side_pwm_out[c] <= 1'b0;
				o_high_side_pwm_oe[c]  <= 1'b0;
				o_low_side_pwm_out[c]  <= 1'b0;
			end else begin
				// Standalone shutdown is a soft-off run by the loop
				o_high_side_pwm_out[c] <= i_hs_pwm_loop[c];
				o_high_side_pwm_oe[c]  <= 1'b1;
				o_low_side_pwm_out[c]  <= i_ls_pwm_loop[c];
			end
		end
	end

	// ==========================================================
	// Snapshot trigger
	logic [15:0] capt_live;

	// Unused positions never trigger, whatever the mask holds
	assign capt_live = i_fault_events & ~capt_mask_reg & CAPT_USED_BITS;

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			o_snapshot_trigger <= 1'b0;
		end else begin
			o_snapshot_trigger <= |capt_live;
		end
	end

	// ==========================================================
	// Checks
	property p_wp_block;
		@(posedge i_clock) disable iff (!i_rst_b)
		i_cmd_valid && i_cmd_write && i_write_protect
			|=> o_rsp_err && $stable(ramp_gain_reg) && $stable(capt_mask_reg);
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("write passed protection");

	property p_reset_vals;
		@(posedge i_clock)
		!i_rst_b |=> pg_delay_reg[0] == RST_PG_DELAY && ramp_gain_reg == RST_RAMP_GAIN
			&& inductance_reg[1] == RST_INDUCTANCE && temp_gain_reg[0] == RST_TEMP_GAIN;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("wrong value after reset");

	property p_gain_write;
		@(posedge i_clock) disable iff (!i_rst_b)
		i_cmd_valid && i_cmd_write && !i_write_protect && i_cmd_code == CMD_RAMP_GAIN
			|=> o_startup_ramp_gain == $past(i_cmd_wdata[7:0]);
	endproperty
	a_gain_write: assert property (p_gain_write) else $error("ramp gain not stored");

	property p_mp_select;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_phases_in_rail == 3'h3) |=> o_multiphase_mode;
	endproperty
	a_mp_select: assert property (p_mp_select) else $error("multiphase not selected");

	property p_loop_ramp;
		@(posedge i_clock) disable iff (!i_rst_b)
		o_multiphase_mode |-> o_fast_adaptive_loop[0] == o_output_good_pin[0];
	endproperty
	a_loop_ramp: assert property (p_loop_ramp) else $error("loop state wrong in ramp");

	property p_standalone;
		@(posedge i_clock) disable iff (!i_rst_b)
		!o_multiphase_mode |-> o_fast_adaptive_loop == 2'b11 && o_soft_off_allowed == 2'b11;
	endproperty
	a_standalone: assert property (p_standalone) else $error("standalone loop off");

	property p_no_soft_off;
		@(posedge i_clock) disable iff (!i_rst_b)
		o_multiphase_mode |-> o_soft_off_allowed == 2'b00;
	endproperty
	a_no_soft_off: assert property (p_no_soft_off) else $error("soft-off in multiphase");

	property p_mp_shutdown;
		@(posedge i_clock) disable iff (!i_rst_b)
		o_multiphase_mode && i_shutdown_cmd[0] && !ov_trip_reg[0]
			|=> !o_high_side_pwm_oe[0] && !o_low_side_pwm_out[0];
	endproperty
	a_mp_shutdown: assert property (p_mp_shutdown) else $error("shutdown pins wrong");

	property p_ov_low_side;
		@(posedge i_clock) disable iff (!i_rst_b)
		ov_trip_reg[0] |=> o_low_side_pwm_out[0] == $past(filter_cfg_reg[0][7])
			&& !o_high_side_pwm_oe[0];
	endproperty
	a_ov_low_side: assert property (p_ov_low_side) else $error("OV low-side wrong");

	property p_capt_mask;
		@(posedge i_clock) disable iff (!i_rst_b)
		(i_fault_events & ~capt_mask_reg & 16'h3cff) == 16'h0 |=> !o_snapshot_trigger;
	endproperty
	a_capt_mask: assert property (p_capt_mask) else $error("masked fault captured");

	property p_pg_drop;
		@(posedge i_clock) disable iff (!i_rst_b)
		!i_vout_above_pg[0] |=> !o_output_good_pin[0];
	endproperty
	a_pg_drop: assert property (p_pg_drop) else $error("output good held low voltage");

	property p_filter_zero;
		@(posedge i_clock) disable iff (!i_rst_b)
		filter_cfg_reg[1][3:0] == 4'h0 && i_vsample_valid[1] && i_ov_violation[1]
			&& !o_ov_fault[1] && $stable(filter_cfg_reg[1]) && !$past(i_ov_violation[1])
			|=> o_ov_fault[1];
	endproperty
	a_filter_zero: assert property (p_filter_zero) else $error("single violation not declared");

	c_pg_good: cover property (@(posedge i_clock) disable iff (!i_rst_b)
		$rose(o_output_good_pin[0]));
	c_mp_shut: cover property (@(posedge i_clock) disable iff (!i_rst_b)
		o_multiphase_mode && i_shutdown_cmd[1]);
	c_ov_trip: cover property (@(posedge i_clock) disable iff (!i_rst_b)
		$rose(ov_trip_reg[1]));
	c_capture: cover property (@(posedge i_clock) disable iff (!i_rst_b)
		o_snapshot_trigger);

endmodule // pocr_regs

`default_nettype wire

// *** bench/pocr_host.sv ***
// Management bus host model driving the command port.
// Assumes the device answers one cycle after each accepted request.
`timescale 1ns/1ns
`default_nettype none

module pocr_host (
	// Clock
	input  wire logic        i_clock,
	// Request
	output logic             o_cmd_valid,
	output logic             o_cmd_write,
	output logic             o_cmd_page,
	output logic [7:0]       o_cmd_code,
	output logic [15:0]      o_cmd_wdata,
	// Answer
	input  wire logic        i_rsp_valid,
	input  wire logic [15:0] i_rsp_rdata,
	input  wire logic        i_rsp_err
);
	// ==========================================================
	// Bus cycle
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd_write = 1'b0;
		o_cmd_page  = 1'b0;
		o_cmd_code  = 8'h00;
		o_cmd_wdata = 16'h0000;
	end

	task automatic xfer(input logic wr, input logic pg, input logic [7:0] code,
		input logic [15:0] wd, output logic [15:0] rd, output logic err);
		rd  = 'x;
		err = 1'bx;
		@(negedge i_clock);
		o_cmd_valid = 1'b1;
		o_cmd_write = wr;
		o_cmd_page  = pg;
		o_cmd_code  = code;
		o_cmd_wdata = wd;
		@(negedge i_clock);
		// Answer stands only in the cycle after the taking edge
		if (i_rsp_valid === 1'b1) begin
			rd  = i_rsp_rdata;
			err = i_rsp_err;
		end
		// Idle lines show the inverse so stale values never look valid
		o_cmd_valid = 1'b0;
		o_cmd_write = ~wr;
		o_cmd_page  = ~pg;
		o_cmd_code  = ~code;
		o_cmd_wdata = ~wd;
	endtask
endmodule // pocr_host

`default_nettype wire

// *** bench/tb.sv ***
// Self-checking bench for the output configuration register bank.
// Assumes pocr_pkg and pocr_regs compiled first; host model drives commands.
`timescale 1ns/1ns
`default_nettype none

module tb;
	import pocr_pkg::*;
	// Short cap keeps the 1 ms delay run brief
	localparam int unsigned PGMAX = 2000;
	logic        clk, rst_b, valid, wr, pg, wp, rsp_v, rsp_err, mp, snap;
	logic [7:0]  code, gain;
	logic [15:0] wdata, rdata, ev, mask;
	logic [2:0]  phases;
	logic [1:0]  above, sv, ov, uv, sd, fclr, hs_l, ls_l;
	logic [1:0]  good, ovf, uvf, fal, soff, hs, hs_oe, ls;
	logic [1:0][15:0] ind, tgain;
	int          n_errors = 0, num_checks = 0, cyc = 0, n_ov = 0, n_uv = 0, n_snap = 0;
	logic [15:0] mdl [bit [8:0]];

	pocr_host u_host (.i_clock(clk), .o_cmd_valid(valid), .o_cmd_write(wr), .o_cmd_page(pg),
		.o_cmd_code(code), .o_cmd_wdata(wdata), .i_rsp_valid(rsp_v),
		.i_rsp_rdata(rdata), .i_rsp_err(rsp_err));
	pocr_regs #(.PG_MAX_TICKS(PGMAX)) u_dut (.i_clock(clk), .i_rst_b(rst_b),
		.i_cmd_valid(valid), .i_cmd_write(wr), .i_cmd_page(pg), .i_cmd_code(code),
		.i_cmd_wdata(wdata), .i_write_protect(wp), .o_rsp_valid(rsp_v),
		.o_rsp_rdata(rdata), .o_rsp_err(rsp_err), .i_phases_in_rail(phases),
		.i_vout_above_pg(above), .i_vsample_valid(sv), .i_ov_violation(ov),
		.i_uv_violation(uv), .i_shutdown_cmd(sd), .i_fault_clear(fclr),
		.i_hs_pwm_loop(hs_l), .i_ls_pwm_loop(ls_l), .i_fault_events(ev),
		.o_output_good_pin(good), .o_ov_fault(ovf), .o_uv_fault(uvf),
		.o_multiphase_mode(mp), .o_fast_adaptive_loop(fal), .o_soft_off_allowed(soff),
		.o_snapshot_trigger(snap), .o_high_side_pwm_out(hs), .o_high_side_pwm_oe(hs_oe),
		.o_low_side_pwm_out(ls), .o_startup_ramp_gain(gain), .o_inductance_value(ind),
		.o_ext_temp_gain(tgain));

	// ==========================================================
	// Clock, pulse counters, timeout
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(negedge clk) begin
		if (rst_b === 1'b1) begin
			n_ov += int'(ovf[0] === 1'b1);
			n_uv += int'(uvf[1] === 1'b1);
			n_snap += int'(snap === 1'b1);
		end
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			end_sim();
		end
	end

	// ==========================================================
	// Helpers
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic bit [8:0] key(input logic p, input logic [7:0] c);
		return {p & (c != CMD_RAMP_GAIN) & (c != CMD_CAPT_MASK), c};
	endfunction
	task automatic acc(input logic w, input logic p, input logic [7:0] c, input logic [15:0] d);
		logic [15:0] rd, ex;
		logic        e, hit;
		hit = c >= 8'hd4 && c <= 8'hd9;
		u_host.xfer(w, p, c, d, rd, e);
		ex = 16'h0000;
		if (hit && !w) ex = mdl[key(p, c)];
		else if (hit && !wp) mdl[key(p, c)] = (c == CMD_RAMP_GAIN || c == CMD_FILTER_CFG) ?
			{8'h00, d[7:0]} : d;
		chk("rsp_err", 16'(e), 16'(!hit || (w && wp)));
		chk("rsp_rdata", rd, ex);
		chk("ramp_gain", 16'(gain), mdl[key(0, CMD_RAMP_GAIN)]);
		for (int i = 0; i < 2; i++) begin
			chk("inductance", ind[i], mdl[key(1'(i), CMD_INDUCTANCE)]);
			chk("temp_gain", tgain[i], mdl[key(1'(i), CMD_TEMP_GAIN)]);
		end
	endtask
	task automatic samp(input int ch, input logic o, input logic u);
		@(negedge clk);
		sv[ch] = 1'b1;
		ov[ch] = o;
		uv[ch] = u;
		@(negedge clk);
		sv = 2'b00;
	endtask
	task automatic pg_run(input logic p, input logic [15:0] d, input int lo, input int hi);
		int n;
		acc(1'b1, p, CMD_PG_DELAY, d);
		@(negedge clk);
		above[p] = 1'b1;
		n = 0;
		while (good[p] !== 1'b1 && n < 4000) begin
			@(negedge clk);
			n++;
			if (n == 2) chk("loop_wait", 16'(fal[p]), 16'(phases != 3'h3));
		end
		chk("pg_delay", 16'(n >= lo && n <= hi), 16'h1);
		chk("loop_good", 16'(fal[p]), 16'h1);
		above[p] = 1'b0;
		repeat (2) @(negedge clk);
		chk("pg_fall", 16'(good[p]), 16'h0);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		{rst_b, wp, ev, phases, above, sv, ov, uv, sd, fclr, hs_l, ls_l} = '0;
		void'($urandom(32'hf245aeb0));
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		for (int p = 0; p < 2; p++) begin
			mdl[key(1'(p), CMD_PG_DELAY)] = 16'hba00;
			mdl[key(1'(p), CMD_RAMP_GAIN)] = 16'h0003;
			mdl[key(1'(p), CMD_INDUCTANCE)] = 16'hb133;
			mdl[key(1'(p), CMD_CAPT_MASK)] = 16'h0000;
			mdl[key(1'(p), CMD_FILTER_CFG)] = 16'h0000;
			mdl[key(1'(p), CMD_TEMP_GAIN)] = 16'hba00;
		end
		for (int i = 0; i < 16; i++) acc(1'b0, i[3], 8'hd3 + 8'(i[2:0]), 16'h0000);
		$display("test reset_values done");
		for (int i = 0; i < 80; i++) begin
			@(negedge clk);
			wp = $urandom_range(3) == 0;
			acc(1'($urandom), 1'($urandom), 8'hd3 + 8'($urandom_range(7)), 16'($urandom));
		end
		wp = 1'b0;
		$display("test random_access done");
		phases = 3'h1;
		pg_run(1'b0, 16'h0400, 2, 2);
		phases = 3'h3;
		pg_run(1'b1, 16'he801, 1250, 1256);
		pg_run(1'b1, 16'hba00, 2500, 2506);
		$display("test power_good done");
		for (int m = 0; m < 2; m++) begin
			@(negedge clk);
			{phases, hs_l, ls_l, sd} = {m[0] ? 3'h3 : 3'h1, 6'b011111};
			repeat (3) @(negedge clk);
			chk("mp_mode", 16'(mp), 16'(m));
			chk("soft_off", 16'(soff), m[0] ? 16'h0 : 16'h3);
			chk("fast_loop", 16'(fal), m[0] ? 16'h0 : 16'h3);
			chk("pwm_pins", {hs_oe, ls, hs}, m[0] ? 6'b000000 : 6'b111101);
		end
		{phases, sd} = '0;
		$display("test shutdown done");
		acc(1'b1, 1'b0, CMD_FILTER_CFG, 16'h0082);
		acc(1'b1, 1'b1, CMD_FILTER_CFG, 16'h0000);
		n_ov = 0;
		samp(0, 1, 0);
		samp(0, 1, 0);
		samp(0, 0, 0);
		for (int i = 0; i < 4; i++) samp(0, 1, 0);
		samp(1, 1, 1);
		repeat (3) @(negedge clk);
		chk("ov_count", 16'(n_ov), 16'h1);
		chk("uv_count", 16'(n_uv), 16'h1);
		chk("trip_pins", {hs_oe, ls}, 4'b0001);
		fclr = 2'b11;
		@(negedge clk);
		fclr = 2'b00;
		repeat (2) @(negedge clk);
		chk("cleared_oe", 16'(hs_oe), 16'h3);
		$display("test ovuv done");
		for (int r = 0; r < 2; r++) begin
			mask = r ? 16'($urandom) : 16'h0000;
			acc(1'b1, 1'($urandom), CMD_CAPT_MASK, mask);
			for (int b = 0; b < 16; b++) begin
				n_snap = 0;
				@(negedge clk);
				ev = 16'h1 << b;
				@(negedge clk);
				ev = 16'h0;
				repeat (2) @(negedge clk);
				chk("snapshot", 16'(n_snap), 16'(!mask[b] && !(b inside {8, 9, 14, 15})));
			end
		end
		$display("test snapshot_mask done");
		end_sim();
	end
endmodule // tb

`default_nettype wire
